// ### core/cbs_consts.svh
// constants of the bus cycle sequencer: opcode fields, reset values, zero page
// assumes inclusion by the package, the execution unit and the sequencer only
// Functional notes
// - data bus is captured only on the edge that closes phase two.
// - write cycles never stall on ready; stepping halts in the next read.
// - each instruction opens with an opcode fetch cycle and runs to the next.
// - single-byte instructions take exactly two bus cycles.
// - second cycle of single-byte op reads program_counter plus one, byte discarded.
// - next fetch rereads that same address and executes the byte found.
// - shift-left, rotate-left and shift-right single-byte ops work on the accumulator.
// - address high byte drives lines 15..8, low byte drives lines 7..0.
// - zero page and absolute take operand bytes; indexed modes add an index.
// - opcode byte holds both operation and addressing mode.
// - data bus is driven only in phase two, never in phase one.
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

`define CBS_OP_MSB     7
`define CBS_OP_LSB     4
`define CBS_MODE_MSB   3
`define CBS_MODE_LSB   0
`define CBS_RESET_PC   16'h0000
`define CBS_ZERO_PAGE  8'h00
`define CBS_BYTE_ZERO  8'h00
`define CBS_BYTE_ONE   8'h01

`endif

// ### core/cbs_pkg.sv
// types of the bus cycle sequencer
// assumes cbs_consts.svh is on the include path
`include "cbs_consts.svh"

package cbs_pkg;

	// bus cycle within an instruction, gray along the longest path
	typedef enum logic [2:0] {
		CBS_FIRST_CYCLE  = 3'h0,
		CBS_SECOND_CYCLE = 3'h1,
		CBS_THIRD_CYCLE  = 3'h3,
		CBS_FOURTH_CYCLE = 3'h2,
		CBS_FIFTH_CYCLE  = 3'h6,
		CBS_SIXTH_CYCLE  = 3'h7
	} cbs_cyc_t;

	typedef enum logic [3:0] {
		CBS_MODE_IMPLIED = 4'h0,
		CBS_MODE_IMM     = 4'h1,
		CBS_MODE_ZP      = 4'h2,
		CBS_MODE_ABS     = 4'h3,
		CBS_MODE_ZPX     = 4'h4,
		CBS_MODE_ABSX    = 4'h5,
		CBS_MODE_ABSY    = 4'h6,
		CBS_MODE_INDX    = 4'h7,
		CBS_MODE_INDY    = 4'h8
	} cbs_mode_t;

	typedef enum logic [3:0] {
		CBS_IMP_NOP   = 4'h0,
		CBS_IMP_TAX   = 4'h1,
		CBS_IMP_TAY   = 4'h2,
		CBS_IMP_TXA   = 4'h3,
		CBS_IMP_TYA   = 4'h4,
		CBS_IMP_INX   = 4'h5,
		CBS_IMP_INY   = 4'h6,
		CBS_IMP_DEX   = 4'h7,
		CBS_IMP_DEY   = 4'h8,
		CBS_IMP_CLC   = 4'h9,
		CBS_IMP_SEC   = 4'ha,
		CBS_IMP_SHL   = 4'hb,
		CBS_IMP_ROL   = 4'hc,
		CBS_IMP_SHR   = 4'hd
	} cbs_imp_op_t;

	typedef enum logic [3:0] {
		CBS_MEM_LOAD_A  = 4'h0,
		CBS_MEM_LOAD_X  = 4'h1,
		CBS_MEM_LOAD_Y  = 4'h2,
		CBS_MEM_ADD     = 4'h3,
		CBS_MEM_AND     = 4'h4,
		CBS_MEM_OR      = 4'h5,
		CBS_MEM_XOR     = 4'h6,
		CBS_MEM_STORE_A = 4'h7,
		CBS_MEM_STORE_X = 4'h8,
		CBS_MEM_STORE_Y = 4'h9
	} cbs_mem_op_t;

	typedef struct packed {
		logic [7:0] acc;
		logic [7:0] idx_x;
		logic [7:0] idx_y;
		logic       carry;
		logic       zero;
		logic       neg;
	} cbs_regs_t;

	typedef struct packed {
		logic [15:0] addr;
		logic        rw;
		logic [7:0]  dout;
	} cbs_bus_t;

	function automatic logic cbs_is_store(input logic [7:0] opcode);
		logic [3:0] op;
		op = opcode[`CBS_OP_MSB:`CBS_OP_LSB];
		return (op == CBS_MEM_STORE_A) || (op == CBS_MEM_STORE_X) || (op == CBS_MEM_STORE_Y);
	endfunction

	// unknown mode codes run as a single-byte implied instruction with the same operation field
	function automatic cbs_mode_t cbs_mode(input logic [7:0] opcode);
		logic [3:0] m;
		m = opcode[`CBS_MODE_MSB:`CBS_MODE_LSB];
		return (m > 4'h8) ? CBS_MODE_IMPLIED : cbs_mode_t'(m);
	endfunction

	// low byte sum with carry out, used by every indexed step
	function automatic logic [8:0] cbs_add8(input logic [7:0] a, input logic [7:0] b);
		return {1'b0, a} + {1'b0, b};
	endfunction

endpackage

// ### core/cbs_phase_gen.sv
// two-phase bus clock divider: one bus cycle is two clk periods
// assumes clk at 125 MHz; phase one first after reset
`timescale 1ns/1ps
`default_nettype none

module cbs_phase_gen (
	input  wire logic clk,
	input  wire logic arst_n,
	output var  logic phase_two_r,
	output var  logic phase_one_r
);

	logic phase_two_nxt;

	always_comb begin
		phase_two_nxt = ~phase_two_r;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			phase_two_r <= 1'b0;
			phase_one_r <= 1'b1;
		end else begin
			phase_two_r <= phase_two_nxt;
			phase_one_r <= ~phase_two_nxt;
		end
	end

endmodule

`default_nettype wire

// ### core/cbs_exec.sv
// execution unit: applies the decoded operation to the register set
// assumes the caller only uses the result on the cycle that completes an op
`timescale 1ns/1ps
`default_nettype none
`include "cbs_consts.svh"

module cbs_exec (
	input  wire logic [7:0]        opcode,
	input  wire logic [7:0]        data,
	input  wire cbs_pkg::cbs_regs_t regs_in,
	output var  cbs_pkg::cbs_regs_t regs_out
);

	logic [3:0] op;
	logic [8:0] sum;
	logic [7:0] res;
	logic       upd;

	always_comb begin
		op       = opcode[`CBS_OP_MSB:`CBS_OP_LSB];
		regs_out = regs_in;
		sum      = {1'b0, regs_in.acc} + {1'b0, data} + {8'h00, regs_in.carry};
		res      = regs_in.acc;
		upd      = 1'b1;
		if (cbs_pkg::cbs_mode(opcode) == cbs_pkg::CBS_MODE_IMPLIED) begin
			unique case (op)
				cbs_pkg::CBS_IMP_TAX: begin res = regs_in.acc; regs_out.idx_x = res; end
				cbs_pkg::CBS_IMP_TAY: begin res = regs_in.acc; regs_out.idx_y = res; end
				cbs_pkg::CBS_IMP_TXA: begin res = regs_in.idx_x; regs_out.acc = res; end
				cbs_pkg::CBS_IMP_TYA: begin res = regs_in.idx_y; regs_out.acc = res; end
				cbs_pkg::CBS_IMP_INX: begin res = regs_in.idx_x + 8'h01; regs_out.idx_x = res; end
				cbs_pkg::CBS_IMP_INY: begin res = regs_in.idx_y + 8'h01; regs_out.idx_y = res; end
				cbs_pkg::CBS_IMP_DEX: begin res = regs_in.idx_x - 8'h01; regs_out.idx_x = res; end
				cbs_pkg::CBS_IMP_DEY: begin res = regs_in.idx_y - 8'h01; regs_out.idx_y = res; end
				cbs_pkg::CBS_IMP_CLC: begin upd = 1'b0; regs_out.carry = 1'b0; end
				cbs_pkg::CBS_IMP_SEC: begin upd = 1'b0; regs_out.carry = 1'b1; end
				cbs_pkg::CBS_IMP_SHL: begin res = {regs_in.acc[6:0], 1'b0};
					regs_out.carry = regs_in.acc[7]; regs_out.acc = res; end
				cbs_pkg::CBS_IMP_ROL: begin res = {regs_in.acc[6:0], regs_in.carry};
					regs_out.carry = regs_in.acc[7]; regs_out.acc = res; end
				cbs_pkg::CBS_IMP_SHR: begin res = {1'b0, regs_in.acc[7:1]};
					regs_out.carry = regs_in.acc[0]; regs_out.acc = res; end
				default: upd = 1'b0;
			endcase
		end else begin
			unique case (op)
				cbs_pkg::CBS_MEM_LOAD_A: begin res = data; regs_out.acc = res; end
				cbs_pkg::CBS_MEM_LOAD_X: begin res = data; regs_out.idx_x = res; end
				cbs_pkg::CBS_MEM_LOAD_Y: begin res = data; regs_out.idx_y = res; end
				cbs_pkg::CBS_MEM_ADD: begin res = sum[7:0]; regs_out.acc = res; regs_out.carry = sum[8]; end
				cbs_pkg::CBS_MEM_AND: begin res = regs_in.acc & data; regs_out.acc = res; end
				cbs_pkg::CBS_MEM_OR: begin res = regs_in.acc | data; regs_out.acc = res; end
				cbs_pkg::CBS_MEM_XOR: begin res = regs_in.acc ^ data; regs_out.acc = res; end
				default: upd = 1'b0;
			endcase
		end
		if (upd) begin
			regs_out.zero = (res == 8'h00);
			regs_out.neg  = res[7];
		end
	end

endmodule

`default_nettype wire

// ### core/cbs_seq.sv
// bus cycle sequencer of an 8-bit processor: fetch, addressing, read/write cycles
// assumes memories answer within phase two; ready sampled at the end of phase two
`timescale 1ns/1ps
`default_nettype none
`include "cbs_consts.svh"

module cbs_seq (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        rdy,
	input  wire logic [7:0]  data_in,
	output var  logic [15:0] addr_r,
	output var  logic        rw_r,
	output var  logic [7:0]  data_out_r,
	output var  logic        data_oe_r,
	output var  logic        phi1_r,
	output var  logic        phi2_r,
	output var  logic        first_cycle_r
);

	logic               phase_two;
	logic               phase_one;
	logic               adv;
	cbs_pkg::cbs_mode_t mode;
	logic               store;
	cbs_pkg::cbs_regs_t regs_exec;

	cbs_pkg::cbs_cyc_t  cyc_r, cyc_nxt;
	cbs_pkg::cbs_bus_t  bus_r, bus_nxt;
	cbs_pkg::cbs_regs_t regs_r, regs_nxt;
	logic [15:0]        program_counter_r, program_counter_nxt;
	logic [7:0]         opcode_r, opcode_nxt;
	logic [7:0]         base_addr_low_r, base_addr_low_nxt;
	logic [7:0]         base_addr_high_r, base_addr_high_nxt;
	logic [7:0]         indirect_addr_low_r, indirect_addr_low_nxt;
	// carry out of the low-byte add decides whether a read takes a fix-up cycle; stores always take it
	logic               page_carry_r, page_carry_nxt;
	logic               data_oe_nxt;
	logic               fetch_r, fetch_nxt;
	logic [8:0]         sum;
	logic [7:0]         index;

	cbs_phase_gen u_phase (
		.clk         (clk),
		.arst_n      (arst_n),
		.phase_two_r (phase_two),
		.phase_one_r (phase_one)
	);

	cbs_exec u_exec (
		.opcode   (opcode_r),
		.data     (data_in),
		.regs_in  (regs_r),
		.regs_out (regs_exec)
	);

	// write cycles run through regardless of ready so stepping halts in a read
	assign adv   = phase_two && (!bus_r.rw || rdy);
	assign mode  = cbs_pkg::cbs_mode(opcode_r);
	assign store = cbs_pkg::cbs_is_store(opcode_r);
	// abs,Y and (ind),Y index with Y; every other indexed mode uses X
	assign index = (mode == cbs_pkg::CBS_MODE_ABSY || mode == cbs_pkg::CBS_MODE_INDY) ? regs_r.idx_y
	             : regs_r.idx_x;

	function automatic logic [7:0] store_value(input logic [7:0] opc, input cbs_pkg::cbs_regs_t r);
		logic [3:0] op;
		op = opc[`CBS_OP_MSB:`CBS_OP_LSB];
		if (op == cbs_pkg::CBS_MEM_STORE_X) begin
			return r.idx_x;
		end else if (op == cbs_pkg::CBS_MEM_STORE_Y) begin
			return r.idx_y;
		end
		return r.acc;
	endfunction

	// place a full address: high byte on lines 15..8, low byte on 7..0
	function automatic logic [15:0] place(input logic [7:0] high, input logic [7:0] low);
		return {high, low};
	endfunction

	always_comb begin
		cyc_nxt               = cyc_r;
		bus_nxt               = bus_r;
		regs_nxt              = regs_r;
		program_counter_nxt   = program_counter_r;
		opcode_nxt            = opcode_r;
		base_addr_low_nxt     = base_addr_low_r;
		base_addr_high_nxt    = base_addr_high_r;
		indirect_addr_low_nxt = indirect_addr_low_r;
		page_carry_nxt        = page_carry_r;
		sum                   = 9'h000;
		if (adv) begin
			bus_nxt.rw = 1'b1;
			unique case (cyc_r)
				cbs_pkg::CBS_FIRST_CYCLE: begin
					opcode_nxt          = data_in;
					program_counter_nxt = program_counter_r + 16'h0001;
					bus_nxt.addr        = program_counter_r + 16'h0001;
					cyc_nxt             = cbs_pkg::CBS_SECOND_CYCLE;
				end
				cbs_pkg::CBS_SECOND_CYCLE: begin
					unique case (mode)
						cbs_pkg::CBS_MODE_IMPLIED: begin
							// byte read here is dropped; the same address is fetched again
							regs_nxt     = regs_exec;
							bus_nxt.addr = program_counter_r;
							cyc_nxt      = cbs_pkg::CBS_FIRST_CYCLE;
						end
						cbs_pkg::CBS_MODE_IMM: begin
							regs_nxt            = regs_exec;
							program_counter_nxt = program_counter_r + 16'h0001;
							bus_nxt.addr        = program_counter_r + 16'h0001;
							cyc_nxt             = cbs_pkg::CBS_FIRST_CYCLE;
						end
						cbs_pkg::CBS_MODE_ZP: begin
							base_addr_low_nxt   = data_in;
							program_counter_nxt = program_counter_r + 16'h0001;
							bus_nxt.addr        = place(`CBS_ZERO_PAGE, data_in);
							bus_nxt.rw          = !store;
							cyc_nxt             = cbs_pkg::CBS_THIRD_CYCLE;
						end
						cbs_pkg::CBS_MODE_ZPX, cbs_pkg::CBS_MODE_INDX, cbs_pkg::CBS_MODE_INDY: begin
							base_addr_low_nxt     = data_in;
							indirect_addr_low_nxt = data_in;
							program_counter_nxt   = program_counter_r + 16'h0001;
							bus_nxt.addr          = place(`CBS_ZERO_PAGE, data_in);
							cyc_nxt               = cbs_pkg::CBS_THIRD_CYCLE;
						end
						default: begin
							base_addr_low_nxt   = data_in;
							program_counter_nxt = program_counter_r + 16'h0001;
							bus_nxt.addr        = program_counter_r + 16'h0001;
							cyc_nxt             = cbs_pkg::CBS_THIRD_CYCLE;
						end
					endcase
				end
				cbs_pkg::CBS_THIRD_CYCLE: begin
					cyc_nxt = cbs_pkg::CBS_FOURTH_CYCLE;
					unique case (mode)
						cbs_pkg::CBS_MODE_ABS: begin
							base_addr_high_nxt  = data_in;
							program_counter_nxt = program_counter_r + 16'h0001;
							bus_nxt.addr        = place(data_in, base_addr_low_r);
							bus_nxt.rw          = !store;
						end
						cbs_pkg::CBS_MODE_ABSX, cbs_pkg::CBS_MODE_ABSY: begin
							sum                 = cbs_pkg::cbs_add8(base_addr_low_r, index);
							base_addr_high_nxt  = data_in;
							base_addr_low_nxt   = sum[7:0];
							page_carry_nxt      = sum[8];
							program_counter_nxt = program_counter_r + 16'h0001;
							bus_nxt.addr        = place(data_in, sum[7:0]);
						end
						cbs_pkg::CBS_MODE_ZPX, cbs_pkg::CBS_MODE_INDX: begin
							// index wraps inside page zero
							sum               = cbs_pkg::cbs_add8(base_addr_low_r, index);
							base_addr_low_nxt = sum[7:0];
							bus_nxt.addr      = place(`CBS_ZERO_PAGE, sum[7:0]);
							bus_nxt.rw        = !(store && mode == cbs_pkg::CBS_MODE_ZPX);
						end
						cbs_pkg::CBS_MODE_INDY: begin
							base_addr_low_nxt = data_in;
							sum               = cbs_pkg::cbs_add8(indirect_addr_low_r, `CBS_BYTE_ONE);
							bus_nxt.addr      = place(`CBS_ZERO_PAGE, sum[7:0]);
						end
						default: begin
							regs_nxt     = regs_exec;
							bus_nxt.addr = program_counter_r;
							cyc_nxt      = cbs_pkg::CBS_FIRST_CYCLE;
						end
					endcase
				end
				cbs_pkg::CBS_FOURTH_CYCLE: begin
					cyc_nxt = cbs_pkg::CBS_FIFTH_CYCLE;
					unique case (mode)
						cbs_pkg::CBS_MODE_ABSX, cbs_pkg::CBS_MODE_ABSY: begin
							if (!store && !page_carry_r) begin
								regs_nxt     = regs_exec;
								bus_nxt.addr = program_counter_r;
								cyc_nxt      = cbs_pkg::CBS_FIRST_CYCLE;
							end else begin
								sum          = cbs_pkg::cbs_add8(base_addr_high_r, {7'h00, page_carry_r});
								bus_nxt.addr = place(sum[7:0], base_addr_low_r);
								bus_nxt.rw   = !store;
							end
						end
						cbs_pkg::CBS_MODE_INDX: begin
							base_addr_low_nxt = data_in;
							sum               = cbs_pkg::cbs_add8(base_addr_low_r, `CBS_BYTE_ONE);
							bus_nxt.addr      = place(`CBS_ZERO_PAGE, sum[7:0]);
						end
						cbs_pkg::CBS_MODE_INDY: begin
							sum                = cbs_pkg::cbs_add8(base_addr_low_r, index);
							base_addr_high_nxt = data_in;
							base_addr_low_nxt  = sum[7:0];
							page_carry_nxt     = sum[8];
							bus_nxt.addr       = place(data_in, sum[7:0]);
						end
						default: begin
							if (bus_r.rw) begin
								regs_nxt = regs_exec;
							end
							bus_nxt.addr = program_counter_r;
							cyc_nxt      = cbs_pkg::CBS_FIRST_CYCLE;
						end
					endcase
				end
				cbs_pkg::CBS_FIFTH_CYCLE: begin
					cyc_nxt = cbs_pkg::CBS_SIXTH_CYCLE;
					if (mode == cbs_pkg::CBS_MODE_INDX) begin
						base_addr_high_nxt = data_in;
						bus_nxt.addr       = place(data_in, base_addr_low_r);
						bus_nxt.rw         = !store;
					end else if (mode == cbs_pkg::CBS_MODE_INDY && (store || page_carry_r)) begin
						sum          = cbs_pkg::cbs_add8(base_addr_high_r, {7'h00, page_carry_r});
						bus_nxt.addr = place(sum[7:0], base_addr_low_r);
						bus_nxt.rw   = !store;
					end else begin
						if (bus_r.rw) begin
							regs_nxt = regs_exec;
						end
						bus_nxt.addr = program_counter_r;
						cyc_nxt      = cbs_pkg::CBS_FIRST_CYCLE;
					end
				end
				default: begin
					if (bus_r.rw) begin
						regs_nxt = regs_exec;
					end
					bus_nxt.addr = program_counter_r;
					cyc_nxt      = cbs_pkg::CBS_FIRST_CYCLE;
				end
			endcase
			bus_nxt.dout = store_value(opcode_r, regs_r);
		end
	end

	// pin strobes have flops of their own so every pin comes straight from one
	always_comb begin
		// drive only during the coming phase two of a write cycle
		data_oe_nxt = phase_two ? 1'b0 : !bus_r.rw;
		fetch_nxt   = (cyc_nxt == cbs_pkg::CBS_FIRST_CYCLE);
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			data_oe_r <= 1'b0;
			fetch_r   <= 1'b1;
		end else begin
			data_oe_r <= data_oe_nxt;
			fetch_r   <= fetch_nxt;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cyc_r               <= cbs_pkg::CBS_FIRST_CYCLE;
			bus_r               <= '{addr: `CBS_RESET_PC, rw: 1'b1, dout: `CBS_BYTE_ZERO};
			program_counter_r   <= `CBS_RESET_PC;
			opcode_r            <= `CBS_BYTE_ZERO;
		end else begin
			cyc_r               <= cyc_nxt;
			bus_r               <= bus_nxt;
			program_counter_r   <= program_counter_nxt;
			opcode_r            <= opcode_nxt;
		end
	end

	// architectural registers move only when an instruction retires
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			regs_r              <= '0;
		end else begin
			regs_r              <= regs_nxt;
		end
	end

	// operand bytes live only for the length of one instruction
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_addr_low_r     <= `CBS_BYTE_ZERO;
			base_addr_high_r    <= `CBS_BYTE_ZERO;
			indirect_addr_low_r <= `CBS_BYTE_ZERO;
			page_carry_r        <= 1'b0;
		end else begin
			base_addr_low_r     <= base_addr_low_nxt;
			base_addr_high_r    <= base_addr_high_nxt;
			indirect_addr_low_r <= indirect_addr_low_nxt;
			page_carry_r        <= page_carry_nxt;
		end
	end

	assign addr_r        = bus_r.addr;
	assign rw_r          = bus_r.rw;
	assign data_out_r    = bus_r.dout;
	assign phi1_r        = phase_one;
	assign phi2_r        = phase_two;
	assign first_cycle_r = fetch_r;

endmodule

`default_nettype wire

// ### tb/cbs_seq_checker.sv
// port checker of the bus cycle sequencer
// assumes it is bound onto cbs_seq; one clock domain, reset async active low
`timescale 1ns/1ps
`default_nettype none

module cbs_seq_checker (
	input wire logic        clk,
	input wire logic        arst_n,
	input wire logic        rdy,
	input wire logic [7:0]  data_in,
	input wire logic [15:0] addr_r,
	input wire logic        rw_r,
	input wire logic [7:0]  data_out_r,
	input wire logic        data_oe_r,
	input wire logic        phi1_r,
	input wire logic        phi2_r,
	input wire logic        first_cycle_r
);
	logic done;
	logic imp_pend_r;
	logic zp_pend_r;

	assign done = phi2_r && (!rw_r || rdy);

	// remembers the kind of fetch just closed, for the cycle after it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			imp_pend_r <= 1'b0;
			zp_pend_r  <= 1'b0;
		end else if (done) begin
			imp_pend_r <= first_cycle_r && (data_in[3:0] == 4'h0);
			zp_pend_r  <= first_cycle_r && (data_in[3:0] == 4'h2);
		end
	end

	default clocking dc @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_phase_one; !phi2_r |=> phi2_r && !phi1_r; endproperty
	a_phase_one: assert property (p_phase_one) else $error("phase two did not follow phase one");
	property p_phase_two; phi2_r |=> !phi2_r && phi1_r; endproperty
	a_phase_two: assert property (p_phase_two) else $error("phase one did not follow phase two");
	property p_oe_only_write; data_oe_r |-> phi2_r && !rw_r; endproperty
	a_oe_only_write: assert property (p_oe_only_write) else $error("data bus driven outside write phase two");
	property p_oe_write; phi1_r && !rw_r |=> data_oe_r && $stable(data_out_r); endproperty
	a_oe_write: assert property (p_oe_write) else $error("write data not driven in phase two");
	property p_write_no_stall; phi2_r && !rw_r |=> rw_r && first_cycle_r; endproperty
	a_write_no_stall: assert property (p_write_no_stall) else $error("write cycle did not complete");
	property p_stall_hold; phi2_r && rw_r && !rdy |=> $stable(addr_r) && rw_r ##1 $stable(addr_r); endproperty
	a_stall_hold: assert property (p_stall_hold) else $error("stalled read did not repeat");
	property p_addr_phase1; !$stable(addr_r) |-> phi1_r; endproperty
	a_addr_phase1: assert property (p_addr_phase1) else $error("address moved outside phase one start");
	property p_implied_second;
		done && first_cycle_r && data_in[3:0] == 4'h0 |=> !first_cycle_r && rw_r && addr_r == $past(addr_r) + 16'h0001;
	endproperty
	a_implied_second: assert property (p_implied_second) else $error("second cycle address wrong");
	property p_implied_refetch; done && imp_pend_r |=> first_cycle_r && $stable(addr_r); endproperty
	a_implied_refetch: assert property (p_implied_refetch) else $error("next fetch not at same address");
	property p_zp_effective; done && zp_pend_r |=> addr_r == {8'h00, $past(data_in)}; endproperty
	a_zp_effective: assert property (p_zp_effective) else $error("page zero address wrong");

	c_stall: cover property (phi2_r && rw_r && !rdy);
	c_write: cover property (data_oe_r && !rdy);
	c_implied: cover property (done && imp_pend_r);
	c_zp: cover property (done && zp_pend_r);
endmodule

bind cbs_seq cbs_seq_checker cbs_seq_checker_i (.clk(clk), .arst_n(arst_n), .rdy(rdy), .data_in(data_in),
	.addr_r(addr_r), .rw_r(rw_r), .data_out_r(data_out_r), .data_oe_r(data_oe_r), .phi1_r(phi1_r),
	.phi2_r(phi2_r), .first_cycle_r(first_cycle_r));

`default_nettype wire

// ### tb/cbs_mem_model.sv
// memory partner of the sequencer: answers reads in phase two, takes writes
// assumes the bus outputs of cbs_seq; slow adds one wait cycle to every read
`timescale 1ns/1ps
`default_nettype none

module cbs_mem_model (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic        slow,
	input  wire logic [15:0] addr_r,
	input  wire logic        rw_r,
	input  wire logic [7:0]  data_out_r,
	input  wire logic        data_oe_r,
	input  wire logic        phi2_r,
	output var  logic [7:0]  data_in,
	output var  logic        rdy
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r;
	logic       waited_r;

	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
	end

	// a released bus shows the inverse of its last value, never a held copy
	assign data_in = (phi2_r && rw_r) ? mem[addr_r] : ~last_r;
	// rdy stays low in writes too: a write has to finish regardless
	assign rdy = slow ? waited_r : 1'b1;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			last_r   <= 8'h00;
			waited_r <= 1'b0;
		end else begin
			last_r <= data_in;
			if (phi2_r) waited_r <= slow && rw_r && !waited_r;
			if (data_oe_r) mem[addr_r] <= data_out_r;
		end
	end
endmodule

`default_nettype wire

// ### tb/test_cpu_bus_cycle_sequencer.sv
// bench of the bus cycle sequencer against a reference run of a random program
// assumes cbs_seq, cbs_mem_model and the bound checker are compiled first
`timescale 1ns/1ps
`default_nettype none

module test_cpu_bus_cycle_sequencer;
	logic        clk;
	logic        arst_n;
	logic        slow;
	logic        rdy;
	logic [7:0]  data_in;
	logic [15:0] addr_r;
	logic        rw_r;
	logic [7:0]  data_out_r;
	logic        data_oe_r;
	logic        phi1_r;
	logic        phi2_r;
	logic        first_cycle_r;
	int          fail_count;
	int          check_count;
	logic [31:0] lfsr;
	logic [7:0]  mirror [0:65535];
	logic [25:0] exp_q [$];
	logic [25:0] e;
	logic [7:0]  ra, rx, ry;
	logic        rc;
	int          pc, gen, half, n, k, m;

	always #4 clk = ~clk;

	cbs_seq cbs_seq_i (.clk(clk), .arst_n(arst_n), .rdy(rdy), .data_in(data_in), .addr_r(addr_r),
		.rw_r(rw_r), .data_out_r(data_out_r), .data_oe_r(data_oe_r), .phi1_r(phi1_r), .phi2_r(phi2_r),
		.first_cycle_r(first_cycle_r));
	cbs_mem_model cbs_mem_model_i (.clk(clk), .arst_n(arst_n), .slow(slow), .addr_r(addr_r), .rw_r(rw_r),
		.data_out_r(data_out_r), .data_oe_r(data_oe_r), .phi2_r(phi2_r), .data_in(data_in), .rdy(rdy));

	function automatic int rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return int'(lfsr[15:0]);
	endfunction

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// the bench mirror and the partner memory always get the same byte
	task automatic put(input int a, input int v);
		mirror[a] = v[7:0];
		cbs_mem_model_i.mem[a] = v[7:0];
		gen = a + 1;
	endtask

	task automatic push(input int a, input int rw, input int d, input int f);
		exp_q.push_back({f[0], rw[0], d[7:0], a[15:0]});
	endtask

	// one instruction of the reference: bus cycles in order, then its effect
	task automatic exec_ref();
		int op, md, f, b1, b2, ea, idx;
		logic [7:0] v;
		op = mirror[pc];
		md = op & 15;
		f = op >> 4;
		b1 = mirror[pc + 1];
		b2 = mirror[pc + 2];
		push(pc, 1, 0, 1);
		if (md == 0) begin
			push(pc + 1, 1, 0, 0);
			case (f)
				1: rx = ra;
				2: ry = ra;
				3: ra = rx;
				4: ra = ry;
				5: rx = rx + 8'h01;
				6: ry = ry + 8'h01;
				7: rx = rx - 8'h01;
				8: ry = ry - 8'h01;
				9: rc = 1'b0;
				10: rc = 1'b1;
				11: {rc, ra} = {ra, 1'b0};
				12: {rc, ra} = {ra, rc};
				13: {ra, rc} = {1'b0, ra};
				default: ;
			endcase
			pc = pc + 1;
		end else begin
			ea = pc + 1;
			if (md > 1) push(pc + 1, 1, 0, 0);
			if (md == 2) ea = b1;
			if (md == 3 || md == 5 || md == 6) begin
				push(pc + 2, 1, 0, 0);
				ea = b2 * 256 + b1;
			end
			if (md == 4 || md == 7) begin
				push(b1, 1, 0, 0);
				ea = (b1 + rx) & 255;
			end
			if (md == 7) begin
				push(ea, 1, 0, 0);
				push((ea + 1) & 255, 1, 0, 0);
				ea = mirror[(ea + 1) & 255] * 256 + mirror[ea];
			end
			if (md == 8) begin
				push(b1, 1, 0, 0);
				push((b1 + 1) & 255, 1, 0, 0);
				b2 = mirror[(b1 + 1) & 255];
				b1 = mirror[b1];
				ea = b2 * 256 + b1;
			end
			if (md >= 5 && md != 7) begin
				idx = (md == 5) ? rx : ry;
				if (b1 + idx > 255 || f >= 7) push(b2 * 256 + ((b1 + idx) & 255), 1, 0, 0);
				ea = (ea + idx) & 65535;
			end
			v = (f == 7) ? ra : (f == 8) ? rx : ry;
			if (f >= 7) begin
				push(ea, 0, v, 0);
				mirror[ea] = v;
			end else begin
				push(ea, 1, 0, 0);
				v = mirror[ea];
				if (f == 0) ra = v;
				if (f == 1) rx = v;
				if (f == 2) ry = v;
				if (f == 3) {rc, ra} = ra + v + rc;
				if (f == 4) ra = ra & v;
				if (f == 5) ra = ra | v;
				if (f == 6) ra = ra ^ v;
			end
			pc = pc + ((md == 3 || md == 5 || md == 6) ? 3 : 2);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// every completed bus cycle is compared with the next reference cycle
	always @(posedge clk) begin
		if (arst_n && phi2_r && (!rw_r || rdy) && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			check("address", addr_r, e[15:0]);
			check("direction", rw_r, e[24]);
			check("fetch flag", first_cycle_r, e[25]);
			if (!e[24]) check("write data", data_out_r, e[23:16]);
		end
	end

	initial begin
		repeat (12000) @(posedge clk);
		fail_count++;
		report_and_stop();
	end

	initial begin
		clk = 1'b0;
		arst_n = 1'b0;
		slow = 1'b0;
		lfsr = 32'h50d5;
		fail_count = 0;
		check_count = 0;
		{ra, rx, ry, rc} = '0;
		for (int i = 0; i < 65536; i++) mirror[i] = 8'h00;
		@(posedge clk);
		for (int i = 16'hc0; i < 16'h100; i++) put(i, rnd());
		for (int i = 16'h2000; i < 16'h2200; i++) put(i, rnd());
		gen = 0;
		for (int i = 0; i < 3; i++) begin
			put(gen, (i << 4) | 1);
			put(gen, rnd());
		end
		// each implied code once, each followed by a page zero store of A, X and Y in turn
		for (int i = 0; i < 14; i++) begin
			put(gen, i << 4);
			put(gen, (7 + i % 3) * 16 + 2);
			put(gen, 8'hc0 + i);
		end
		// the program stays below 0c0, so page zero stores never hit code
		for (int i = 0; i < 40; i++) begin
			if (rnd() % 3 == 0) begin
				put(gen, (rnd() % 14) * 16);
			end else begin
				k = rnd() % 10;
				m = (k > 6) ? 2 + rnd() % 2 + 3 * (rnd() % 2) : 1 + rnd() % 8;
				put(gen, k * 16 + m);
				put(gen, (m == 2) ? (rnd() | 8'hc0) : rnd());
				if (m == 3 || m == 5 || m == 6) put(gen, 8'h20);
			end
		end
		pc = 0;
		while (pc < gen) exec_ref();
		repeat (4) @(posedge clk);
		#1 arst_n = 1'b1;
		half = exp_q.size() / 2;
		for (n = 0; n < 5000 && exp_q.size() > half; n++) @(posedge clk);
		$display("fast memory run done, %0d checks", check_count);
		#1 slow = 1'b1;
		for (n = 0; n < 5000 && exp_q.size() > 0; n++) @(posedge clk);
		$display("slow memory run done, %0d checks", check_count);
		if (exp_q.size() > 0) fail_count++;
		report_and_stop();
	end
endmodule

`default_nettype wire
